// ===== cmbc_pkg.sv
package cmbc_pkg;

  // ****************************************
  // register map, byte addresses
  // ****************************************
  localparam int unsigned CMBC_NUM_MASKS = 3;
  localparam int unsigned CMBC_NUM_RXB = 32;
  localparam int unsigned CMBC_NUM_CFG = 8;
  localparam logic [11:0] CMBC_MSK_BASE = 12'h000;
  localparam logic [11:0] CMBC_MSK_STRIDE = 12'h008;
  localparam logic [11:0] CMBC_MSK_EID_OFS = 12'h004;
  localparam logic [11:0] CMBC_FULL_LO = 12'h018;
  localparam logic [11:0] CMBC_FULL_HI = 12'h01c;
  localparam logic [11:0] CMBC_OVR_LO = 12'h020;
  localparam logic [11:0] CMBC_OVR_HI = 12'h024;
  localparam logic [11:0] CMBC_CTL_BASE = 12'h028;
  localparam logic [11:0] CMBC_WORD = 12'h004;
  localparam logic [15:0] CMBC_REG_RESET = 16'h0000;

  // ****************************************
  // field layout
  // ****************************************
  localparam int unsigned CMBC_SID_HI = 15;
  localparam int unsigned CMBC_SID_LO = 5;
  localparam int unsigned CMBC_TYPE_BIT = 3;
  localparam logic [15:0] CMBC_MSK_SID_WMASK = 16'hffeb;
  localparam int unsigned CMBC_CTL_DIR = 7;
  localparam int unsigned CMBC_CTL_ABT = 6;
  localparam int unsigned CMBC_CTL_ARB = 5;
  localparam int unsigned CMBC_CTL_ERR = 4;
  localparam int unsigned CMBC_CTL_REQ = 3;
  localparam int unsigned CMBC_CTL_RTR = 2;
  localparam int unsigned CMBC_CTL_PRI_HI = 1;
  localparam int unsigned CMBC_CTL_PRI_LO = 0;
  localparam int unsigned CMBC_BYTE = 8;
  localparam logic [1:0] CMBC_MSEL_RSVD = 2'h3;
  localparam logic [1:0] CMBC_HTRANS_NONSEQ = 2'h2;

  // ****************************************
  // carriers
  // ****************************************
  typedef struct packed {
    logic valid;
    logic [10:0] frame_sid;
    logic [17:0] frame_eid;
    logic frame_ext;
    logic [15:0] filter_sid;
    logic [15:0] filter_eid;
    logic [1:0] mask_source_select;
  } cmbc_check_t;

  typedef struct packed {
    logic valid;
    logic [4:0] index;
  } cmbc_rxwr_t;

  typedef struct packed {
    logic valid;
    logic [2:0] index;
  } cmbc_rtr_t;

  typedef struct packed {
    logic valid;
    logic [2:0] index;
    logic success;
    logic aborted;
    logic arb_lost;
    logic bus_error;
  } cmbc_txev_t;

  typedef struct packed {
    logic valid;
    logic [2:0] index;
    logic [1:0] send_priority;
  } cmbc_offer_t;

endpackage : cmbc_pkg

// ===== cmbc_mask_buffer_ctrl.sv
// Chosen here: the register addresses and the AHB-Lite interface to the registers.
`timescale 1ns/1ps

// Function
// - standard id mask bit one compares bit
// - extended mask bits 17..0 across two registers
// - type bit one: frame format must match
// - type bit zero: either format, masked ids
// - standard mask bits 4, 2 read zero
// - 32 occupied flags, set on buffer write
// - write into occupied buffer sets overrun
// - direction bit: one transmit, resets zero
// - low byte even buffer, high odd
// - aborted flag shows last send aborted
// - arbitration lost flag set on loss
// - bus error flag set during sending
// - send request cleared after successful send
// - clearing pending request means abort
// - remote frame sets request when enabled
// - two-bit priority, three highest, zero lowest
// - setting request clears three outcome flags
// - message contents live in shared RAM
// - filter extended select picks frame format
// - mask source 0,1,2; three reserved
module cmbc_mask_buffer_ctrl #(
  parameter int unsigned NUM_RXB = cmbc_pkg::CMBC_NUM_RXB,
  parameter int unsigned NUM_CFG = cmbc_pkg::CMBC_NUM_CFG
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire cmbc_pkg::cmbc_check_t id_check,
  output logic filter_accept_valid,
  output logic filter_accept,
  input wire cmbc_pkg::cmbc_rxwr_t rx_write,
  input wire cmbc_pkg::cmbc_rtr_t remote_hit,
  input wire cmbc_pkg::cmbc_txev_t tx_event,
  output cmbc_pkg::cmbc_offer_t tx_offer,
  output logic [7:0] abort_request
);
  import cmbc_pkg::*;

  // ****************************************
  // state
  // ****************************************
  logic [15:0] mask_sid [CMBC_NUM_MASKS];
  logic [15:0] mask_eid [CMBC_NUM_MASKS];
  // message bodies live in shared memory; only flags kept here
  logic [31:0] rx_buffer_occupied;
  logic [31:0] rx_buffer_overrun;
  logic [7:0] buffer_direction_tx;
  logic [7:0] send_aborted_flag;
  logic [7:0] arbitration_lost_flag;
  logic [7:0] send_bus_error_flag;
  logic [7:0] send_request;
  logic [7:0] auto_remote_reply_enable;
  logic [1:0] send_priority [8];
  logic wr_pending;
  logic [11:0] wr_addr;
  logic addr_phase;
  logic [11:0] ap_addr;
  logic [15:0] rd_value;
  logic [15:0] wdata;
  logic next_accept;
  cmbc_offer_t next_offer;

  // ****************************************
  // helpers
  // ****************************************
  function automatic logic [15:0] cmbc_ctl_byte(input int unsigned b);
    cmbc_ctl_byte = {buffer_direction_tx[b], send_aborted_flag[b], arbitration_lost_flag[b],
                     send_bus_error_flag[b], send_request[b], auto_remote_reply_enable[b],
                     send_priority[b], 8'h00};
  endfunction : cmbc_ctl_byte

  function automatic logic [11:0] cmbc_ctl_addr(input int unsigned b);
    cmbc_ctl_addr = CMBC_CTL_BASE + CMBC_WORD * 12'(b / 2);
  endfunction : cmbc_ctl_addr

  function automatic logic cmbc_match(
    input logic [15:0] msid,
    input logic [15:0] meid,
    input cmbc_check_t c
  );
    logic sid_ok;
    logic eid_ok;
    logic [17:0] emask;
    logic [17:0] efilt;
    emask = {msid[1:0], meid};
    efilt = {c.filter_sid[1:0], c.filter_eid};
    sid_ok = ((c.filter_sid[CMBC_SID_HI:CMBC_SID_LO] ^ c.frame_sid)
              & msid[CMBC_SID_HI:CMBC_SID_LO]) == 11'h000;
    eid_ok = ((efilt ^ c.frame_eid) & emask) == 18'h00000;
    if (msid[CMBC_TYPE_BIT]) begin
      // format must equal the filter's extended select
      cmbc_match = (c.frame_ext == c.filter_sid[CMBC_TYPE_BIT]) && sid_ok
                   && (!c.frame_ext || eid_ok);
    end else begin
      cmbc_match = sid_ok && (!c.frame_ext || eid_ok);
    end
  endfunction : cmbc_match

  // ****************************************
  // ahb-lite slave
  // ****************************************
  assign addr_phase = hsel && htrans[1] && hready;
  assign ap_addr = haddr[11:0];
  assign wdata = hwdata[15:0];

  // zero wait state; no errors, unmapped reads return zero
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pending <= 1'b0;
      wr_addr <= 12'h000;
    end else begin
      wr_pending <= addr_phase && hwrite && (haddr[31:12] == 20'h00000);
      wr_addr <= ap_addr;
    end
  end
  always_comb begin
    rd_value = CMBC_REG_RESET;
    for (int m = 0; m < CMBC_NUM_MASKS; m++) begin
      if (ap_addr == CMBC_MSK_BASE + CMBC_MSK_STRIDE * 12'(m)) begin
        rd_value = mask_sid[m] & CMBC_MSK_SID_WMASK;
      end
      if (ap_addr == CMBC_MSK_BASE + CMBC_MSK_STRIDE * 12'(m) + CMBC_MSK_EID_OFS) begin
        rd_value = mask_eid[m];
      end
    end
    case (ap_addr)
      CMBC_FULL_LO: rd_value = rx_buffer_occupied[15:0];
      CMBC_FULL_HI: rd_value = rx_buffer_occupied[31:16];
      CMBC_OVR_LO: rd_value = rx_buffer_overrun[15:0];
      CMBC_OVR_HI: rd_value = rx_buffer_overrun[31:16];
      default: ;
    endcase
    for (int p = 0; p < 4; p++) begin
      if (ap_addr == cmbc_ctl_addr(2 * p)) begin
        rd_value = cmbc_ctl_byte(2 * p + 1) | (cmbc_ctl_byte(2 * p) >> CMBC_BYTE);
      end
    end
    if (haddr[31:12] != 20'h00000) begin
      rd_value = CMBC_REG_RESET;
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h00000000;
    end else if (addr_phase && !hwrite) begin
      hrdata <= {16'h0000, rd_value};
    end else begin
      hrdata <= 32'h00000000;
    end
  end

  // ****************************************
  // acceptance masks
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      for (int m = 0; m < CMBC_NUM_MASKS; m++) begin
        mask_sid[m] <= CMBC_REG_RESET;
        mask_eid[m] <= CMBC_REG_RESET;
      end
    end else if (wr_pending) begin
      for (int m = 0; m < CMBC_NUM_MASKS; m++) begin
        if (wr_addr == CMBC_MSK_BASE + CMBC_MSK_STRIDE * 12'(m)) begin
          mask_sid[m] <= wdata & CMBC_MSK_SID_WMASK;
        end
        if (wr_addr == CMBC_MSK_BASE + CMBC_MSK_STRIDE * 12'(m) + CMBC_MSK_EID_OFS) begin
          mask_eid[m] <= wdata;
        end
      end
    end
  end

  always_comb begin
    next_accept = 1'b0;
    // reserved source code never accepts
    if (id_check.mask_source_select != CMBC_MSEL_RSVD) begin
      next_accept = cmbc_match(mask_sid[id_check.mask_source_select],
                               mask_eid[id_check.mask_source_select], id_check);
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      filter_accept_valid <= 1'b0;
      filter_accept <= 1'b0;
    end else begin
      filter_accept_valid <= id_check.valid;
      filter_accept <= id_check.valid && next_accept;
    end
  end

  // ****************************************
  // receive occupied and overrun flags
  // ****************************************
  // a buffer write landing with a software clear still wins
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      rx_buffer_occupied <= 32'h00000000;
      rx_buffer_overrun <= 32'h00000000;
    end else begin
      for (int b = 0; b < NUM_RXB; b++) begin
        logic clr_full;
        logic clr_ovr;
        clr_full = wr_pending && !wdata[b % 16]
                   && (wr_addr == ((b < 16) ? CMBC_FULL_LO : CMBC_FULL_HI));
        clr_ovr = wr_pending && !wdata[b % 16]
                  && (wr_addr == ((b < 16) ? CMBC_OVR_LO : CMBC_OVR_HI));
        if (rx_write.valid && rx_write.index == 5'(b)) begin
          rx_buffer_occupied[b] <= 1'b1;
        end else if (clr_full) begin
          rx_buffer_occupied[b] <= 1'b0;
        end
        if (rx_write.valid && rx_write.index == 5'(b) && rx_buffer_occupied[b]) begin
          rx_buffer_overrun[b] <= 1'b1;
        end else if (clr_ovr) begin
          rx_buffer_overrun[b] <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // buffer pair control
  // ****************************************
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      buffer_direction_tx <= 8'h00;
      send_aborted_flag <= 8'h00;
      arbitration_lost_flag <= 8'h00;
      send_bus_error_flag <= 8'h00;
      send_request <= 8'h00;
      auto_remote_reply_enable <= 8'h00;
      abort_request <= 8'h00;
      for (int b = 0; b < 8; b++) begin
        send_priority[b] <= 2'h0;
      end
    end else begin
      for (int b = 0; b < NUM_CFG; b++) begin
        logic sw_wr;
        logic [7:0] wb;
        logic set_req;
        logic ev;
        sw_wr = wr_pending && (wr_addr == cmbc_ctl_addr(b));
        wb = wdata[(b % 2) * CMBC_BYTE +: CMBC_BYTE];
        ev = tx_event.valid && tx_event.index == 3'(b);
        set_req = (sw_wr && wb[CMBC_CTL_REQ] && !send_request[b])
                  || (remote_hit.valid && remote_hit.index == 3'(b)
                      && auto_remote_reply_enable[b]);
        if (sw_wr) begin
          buffer_direction_tx[b] <= wb[CMBC_CTL_DIR];
          auto_remote_reply_enable[b] <= wb[CMBC_CTL_RTR];
          send_priority[b] <= wb[CMBC_CTL_PRI_HI:CMBC_CTL_PRI_LO];
        end
        // request: set beats the engine's clear
        if (set_req) begin
          send_request[b] <= 1'b1;
        end else if (sw_wr && !wb[CMBC_CTL_REQ]) begin
          send_request[b] <= 1'b0;
        end else if (ev && (tx_event.success || tx_event.aborted)) begin
          send_request[b] <= 1'b0;
        end
        if (sw_wr && !wb[CMBC_CTL_REQ] && send_request[b]) begin
          abort_request[b] <= 1'b1;
        end else if (set_req || (ev && (tx_event.success || tx_event.aborted))) begin
          abort_request[b] <= 1'b0;
        end
        // outcome flags: engine event beats the clear on request
        if (ev && tx_event.aborted) begin
          send_aborted_flag[b] <= 1'b1;
        end else if (set_req || (ev && tx_event.success)) begin
          send_aborted_flag[b] <= 1'b0;
        end
        if (ev && tx_event.arb_lost) begin
          arbitration_lost_flag[b] <= 1'b1;
        end else if (set_req) begin
          arbitration_lost_flag[b] <= 1'b0;
        end
        if (ev && tx_event.bus_error) begin
          send_bus_error_flag[b] <= 1'b1;
        end else if (set_req) begin
          send_bus_error_flag[b] <= 1'b0;
        end
      end
    end
  end

  // ****************************************
  // transmit selection
  // ****************************************
  // strict compare while scanning upward keeps the lower index on ties
  always_comb begin
    next_offer = '0;
    for (int b = 0; b < NUM_CFG; b++) begin
      if (buffer_direction_tx[b] && send_request[b] && !abort_request[b]) begin
        if (!next_offer.valid || send_priority[b] > next_offer.send_priority) begin
          next_offer.valid = 1'b1;
          next_offer.index = 3'(b);
          next_offer.send_priority = send_priority[b];
        end
      end
    end
  end
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_offer <= '0;
    end else begin
      tx_offer <= next_offer;
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_rxw_busy;
    rx_write.valid && rx_buffer_occupied[rx_write.index];
  endsequence
  property p_full_set;
    @(posedge hclk) disable iff (!hresetn)
      rx_write.valid |=> rx_buffer_occupied[$past(rx_write.index)];
  endproperty
  a_full_set: assert property (p_full_set) else $error("occupied flag not set");
  property p_overrun;
    @(posedge hclk) disable iff (!hresetn)
      s_rxw_busy |=> rx_buffer_overrun[$past(rx_write.index)];
  endproperty
  a_overrun: assert property (p_overrun) else $error("overrun flag not set");
  property p_rsvd_read;
    @(posedge hclk) disable iff (!hresetn)
      (addr_phase && !hwrite && ap_addr == CMBC_MSK_BASE)
        |=> hrdata[4] == 1'b0 && hrdata[2] == 1'b0;
  endproperty
  a_rsvd_read: assert property (p_rsvd_read) else $error("mask bits 4 or 2 read one");
  property p_type_mismatch;
    @(posedge hclk) disable iff (!hresetn)
      (id_check.valid && mask_sid[0][CMBC_TYPE_BIT] && id_check.mask_source_select == 2'h0
       && id_check.frame_ext != id_check.filter_sid[CMBC_TYPE_BIT]) |=> !filter_accept;
  endproperty
  a_type_mismatch: assert property (p_type_mismatch) else $error("wrong format accepted");
  property p_all_care_off;
    @(posedge hclk) disable iff (!hresetn)
      (id_check.valid && id_check.mask_source_select == 2'h1 && mask_sid[1] == 16'h0000
       && mask_eid[1] == 16'h0000) |=> filter_accept;
  endproperty
  a_all_care_off: assert property (p_all_care_off) else $error("empty mask rejected");
  property p_rsvd_src;
    @(posedge hclk) disable iff (!hresetn)
      id_check.mask_source_select == CMBC_MSEL_RSVD |=> !filter_accept;
  endproperty
  a_rsvd_src: assert property (p_rsvd_src) else $error("reserved source accepted");
  // buffer 2 is the one whose flags get set before a remote reply re-arms it
  property p_req_clears;
    @(posedge hclk) disable iff (!hresetn)
      ($rose(send_request[2]) && !$past(tx_event.valid))
        |-> !send_aborted_flag[2] && !arbitration_lost_flag[2] && !send_bus_error_flag[2];
  endproperty
  a_req_clears: assert property (p_req_clears) else $error("outcome flags kept");
  property p_remote;
    @(posedge hclk) disable iff (!hresetn)
      (remote_hit.valid && auto_remote_reply_enable[remote_hit.index])
        |=> send_request[$past(remote_hit.index)];
  endproperty
  a_remote: assert property (p_remote) else $error("remote reply not requested");
  property p_success;
    @(posedge hclk) disable iff (!hresetn)
      (tx_event.valid && tx_event.success && !wr_pending && !remote_hit.valid)
        |=> !send_request[$past(tx_event.index)]
        ##1 (!tx_offer.valid || tx_offer.index != $past(tx_event.index, 2));
  endproperty
  a_success: assert property (p_success) else $error("request kept after send");
  property p_offer_best;
    @(posedge hclk) disable iff (!hresetn)
      tx_offer.valid |-> tx_offer.send_priority >= $past(send_priority[2])
        || !$past(send_request[2] && buffer_direction_tx[2] && !abort_request[2]);
  endproperty
  a_offer_best: assert property (p_offer_best) else $error("lower priority offered");
endmodule : cmbc_mask_buffer_ctrl

// ===== cmbc_engine_model.sv
`timescale 1ns/1ps

// ****************************************
// protocol engine stand-in
// ****************************************
module cmbc_engine_model #(
  parameter int DELAY = 3
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic [1:0] mode,
  input wire cmbc_pkg::cmbc_offer_t tx_offer,
  input wire logic [7:0] abort_request,
  output cmbc_pkg::cmbc_txev_t tx_event
);
  import cmbc_pkg::*;
  int cnt;
  logic busy;
  logic [2:0] abt_idx;

  always_comb begin
    abt_idx = 3'h0;
    for (int i = 7; i >= 0; i--) begin
      if (abort_request[i]) begin
        abt_idx = 3'(i);
      end
    end
  end

  // idle fields toggle, so a design that ignores valid is caught
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      busy <= 1'b0;
      cnt <= 0;
      tx_event <= '0;
    end else begin
      if (go) begin
        busy <= 1'b1;
        cnt <= DELAY;
        tx_event <= {1'b0, ~tx_event[6:0]};
      end else if (busy && cnt > 0) begin
        cnt <= cnt - 1;
        tx_event <= {1'b0, ~tx_event[6:0]};
      end else if (busy) begin
        busy <= 1'b0;
        if (|abort_request) begin
          tx_event <= '{1'b1, abt_idx, 1'b0, 1'b1, 1'b0, 1'b0};
        end else begin
          tx_event <= '{1'b1, tx_offer.index, mode == 2'h0, 1'b0,
                        mode == 2'h1, mode == 2'h2};
        end
      end else begin
        tx_event <= {1'b0, ~tx_event[6:0]};
      end
    end
  end
endmodule : cmbc_engine_model

// ===== tb.sv
`timescale 1ns/1ps

`define CHK(act, exp) begin tests_run++; if ((act) !== (exp)) begin num_errors++; \
  $display("MISMATCH t=%0t got %h exp %h", $time, act, exp); end end

// ****************************************
// testbench
// ****************************************
module tb;
  import cmbc_pkg::*;
  logic hclk, hresetn, hsel, hwrite, hreadyout, hresp, fav, fa, go;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans, mode;
  logic [7:0] abort_request;
  cmbc_check_t id_check;
  cmbc_rxwr_t rx_write;
  cmbc_rtr_t remote_hit;
  cmbc_txev_t tx_event;
  cmbc_offer_t tx_offer;
  int num_errors = 0;
  int tests_run = 0;

  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end

  cmbc_mask_buffer_ctrl i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .id_check(id_check),
    .filter_accept_valid(fav), .filter_accept(fa), .rx_write(rx_write),
    .remote_hit(remote_hit), .tx_event(tx_event), .tx_offer(tx_offer),
    .abort_request(abort_request));

  cmbc_engine_model i_eng (.hclk(hclk), .hresetn(hresetn), .go(go), .mode(mode),
    .tx_offer(tx_offer), .abort_request(abort_request), .tx_event(tx_event));

  task end_sim;
    if (num_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : end_sim

  task automatic hang(input int n);
    if (n >= 20) begin
      num_errors++;
      $display("MISMATCH t=%0t wait ran out", $time);
      end_sim;
    end
  endtask : hang

  task automatic rdy;
    int n;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (hreadyout !== 1'b1 && n < 20);
    hang(n);
  endtask : rdy

  task automatic xfer(input logic w, input logic [31:0] a, input logic [15:0] d,
                      output logic [31:0] q);
    haddr <= a;
    htrans <= CMBC_HTRANS_NONSEQ;
    hwrite <= w;
    hsel <= 1'b1;
    rdy;
    htrans <= 2'h0;
    hwdata <= {16'h0, d};
    rdy;
    q = hrdata;
  endtask : xfer

  task automatic wr(input logic [31:0] a, input logic [15:0] d);
    logic [31:0] q;
    xfer(1'b1, a, d, q);
  endtask : wr

  task automatic rd(input logic [31:0] a, input logic [15:0] e);
    logic [31:0] q;
    xfer(1'b0, a, 16'h0, q);
    `CHK(q, {16'h0, e})
    `CHK(hresp, 1'b0)
  endtask : rd

  task automatic flt(input logic [1:0] ms, input logic ext, input logic [10:0] sid,
                     input logic [17:0] eid, input logic [15:0] fs, input logic [15:0] fe,
                     input logic e);
    id_check <= '{1'b1, sid, eid, ext, fs, fe, ms};
    @(posedge hclk);
    id_check.valid <= 1'b0;
    @(posedge hclk);
    `CHK({fav, fa}, {1'b1, e})
  endtask : flt

  task automatic rxw(input logic [4:0] i);
    rx_write <= '{1'b1, i};
    @(posedge hclk);
    rx_write <= '{1'b0, ~i};
    @(posedge hclk);
  endtask : rxw

  task automatic rhit(input logic [2:0] i);
    remote_hit <= '{1'b1, i};
    @(posedge hclk);
    remote_hit <= '{1'b0, ~i};
    @(posedge hclk);
  endtask : rhit

  // one engine outcome, then let flags and offer settle
  task automatic txr(input logic [1:0] m);
    int n;
    go <= 1'b1;
    mode <= m;
    @(posedge hclk);
    go <= 1'b0;
    n = 0;
    do begin
      @(posedge hclk);
      n++;
    end while (tx_event.valid !== 1'b1 && n < 20);
    hang(n);
    repeat (2) @(posedge hclk);
  endtask : txr

  task automatic reset_check;
    for (int a = 'h18; a <= 'h34; a += 4) begin
      rd(32'(a), CMBC_REG_RESET);
    end
    rd(32'h0000_1000, 16'h0);
    `CHK({tx_offer, abort_request}, 14'h0)
  endtask : reset_check

  task automatic mask_check;
    wr(CMBC_MSK_BASE, 16'hffff);
    rd(CMBC_MSK_BASE, 16'hffeb);
    wr(CMBC_MSK_BASE, 16'hffe8);
    wr(CMBC_MSK_STRIDE, 16'h0000);
    wr(2 * CMBC_MSK_STRIDE, 16'hffe3);
    wr(2 * CMBC_MSK_STRIDE + CMBC_MSK_EID_OFS, 16'hffff);
    rd(2 * CMBC_MSK_STRIDE + CMBC_MSK_EID_OFS, 16'hffff);
  endtask : mask_check

  task automatic filter_check;
    flt(2'h0, 1'b0, 11'h123, 18'h0, 16'h2460, 16'h0, 1'b1);
    flt(2'h0, 1'b0, 11'h122, 18'h0, 16'h2460, 16'h0, 1'b0);
    flt(2'h0, 1'b1, 11'h123, 18'h0, 16'h2460, 16'h0, 1'b0);
    flt(2'h0, 1'b1, 11'h123, 18'h0, 16'h2468, 16'h0, 1'b1);
    flt(2'h1, 1'b1, 11'h7ff, 18'h3ffff, 16'h2460, 16'h0, 1'b1);
    flt(2'h2, 1'b1, 11'h123, 18'h100a5, 16'h2461, 16'h00a5, 1'b1);
    flt(2'h2, 1'b1, 11'h123, 18'h000a5, 16'h2461, 16'h00a5, 1'b0);
    flt(2'h2, 1'b1, 11'h123, 18'h100a4, 16'h2461, 16'h00a5, 1'b0);
    flt(CMBC_MSEL_RSVD, 1'b0, 11'h123, 18'h0, 16'h2460, 16'h0, 1'b0);
  endtask : filter_check

  task automatic rx_check;
    rxw(5'd3);
    rxw(5'd20);
    rd(CMBC_FULL_LO, 16'h0008);
    rd(CMBC_FULL_HI, 16'h0010);
    rd(CMBC_OVR_LO, 16'h0000);
    rxw(5'd3);
    rxw(5'd20);
    rd(CMBC_OVR_LO, 16'h0008);
    rd(CMBC_OVR_HI, 16'h0010);
    wr(CMBC_FULL_LO, 16'hfff7);
    rd(CMBC_FULL_LO, 16'h0000);
    wr(CMBC_FULL_HI, 16'hffff);
    rd(CMBC_FULL_HI, 16'h0010);
    wr(CMBC_OVR_LO, 16'hfff7);
    rd(CMBC_OVR_LO, 16'h0000);
  endtask : rx_check

  task automatic tx_check;
    wr(CMBC_CTL_BASE, 16'h8b89);
    repeat (2) @(posedge hclk);
    `CHK(tx_offer, {1'b1, 3'd1, 2'h3})
    wr(CMBC_CTL_BASE + CMBC_WORD, 16'h008b);
    repeat (2) @(posedge hclk);
    `CHK(tx_offer, {1'b1, 3'd1, 2'h3})
    txr(2'h0);
    rd(CMBC_CTL_BASE, 16'h8389);
    `CHK(tx_offer, {1'b1, 3'd2, 2'h3})
    txr(2'h1);
    rd(CMBC_CTL_BASE + CMBC_WORD, 16'h00ab);
    txr(2'h2);
    rd(CMBC_CTL_BASE + CMBC_WORD, 16'h00bb);
    wr(CMBC_CTL_BASE + CMBC_WORD, 16'h0083);
    @(posedge hclk);
    `CHK(abort_request, 8'h04)
    txr(2'h0);
    rd(CMBC_CTL_BASE + CMBC_WORD, 16'h00f3);
    `CHK(abort_request, 8'h00)
    wr(CMBC_CTL_BASE + CMBC_WORD, 16'h0087);
    rhit(3'd2);
    rhit(3'd3);
    rd(CMBC_CTL_BASE + CMBC_WORD, 16'h008f);
  endtask : tx_check

  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    haddr = '0;
    htrans = 2'h0;
    hwrite = 1'b0;
    hwdata = '0;
    id_check = '0;
    rx_write = '0;
    remote_hit = '0;
    go = 1'b0;
    mode = 2'h0;
    repeat (5) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    reset_check;
    mask_check;
    filter_check;
    rx_check;
    tx_check;
    end_sim;
  end
endmodule : tb
